// ==== logic/fsp_pkg.sv ====
package fsp_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // clock and flash strobe timing
   localparam int CLK_NS       = 10;
   localparam int T_STROBE_NS  = 70;
   localparam int T_RECOVER_NS = 30;
   localparam int STROBE_CYC   = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;
   localparam int RECOVER_CYC  = (T_RECOVER_NS + CLK_NS - 1) / CLK_NS;

   ////////////////////////////////////////////////////////////////////////////////
   // register word addresses
   localparam logic [2:0] REG_CTRL   = 3'h0;
   localparam logic [2:0] REG_ADDR   = 3'h1;
   localparam logic [2:0] REG_WDATA  = 3'h2;
   localparam logic [2:0] REG_LIMIT  = 3'h3;
   localparam logic [2:0] REG_STATUS = 3'h4;
   localparam logic [2:0] REG_RDATA  = 3'h5;

   localparam logic [15:0] LIMIT_RST = 16'h0400;

   // status register bit positions
   localparam int ST_BUSY      = 0;
   localparam int ST_DONE      = 1;
   localparam int ST_OK        = 2;
   localparam int ST_FAIL_LIM  = 3;
   localparam int ST_FAIL_TO   = 4;
   localparam int ST_SECT_TOG  = 5;

   ////////////////////////////////////////////////////////////////////////////////
   // commands written to the control register
   localparam logic [2:0] CMD_WRITE       = 3'h1;
   localparam logic [2:0] CMD_READ        = 3'h2;
   localparam logic [2:0] CMD_POLL_TOGGLE = 3'h3;
   localparam logic [2:0] CMD_POLL_DATA   = 3'h4;
   localparam logic [2:0] CMD_RESET       = 3'h5;

   localparam logic [7:0] RESET_BYTE = 8'hF0;

   // status byte bit positions
   localparam int COMPLETION_POLARITY_BIT = 7;
   localparam int TOGGLE_BIT_ONE          = 6;
   localparam int LIMIT_EXCEEDED_BIT      = 5;
   localparam int SECTOR_TOGGLE_BIT       = 2;

   typedef enum logic [2:0] {
      ST_IDLE, ST_WR, ST_RD, ST_RD_A, ST_RD_B, ST_EVAL, ST_FINAL, ST_RESET
   } fsp_state_t;

   typedef enum logic [1:0] {
      CY_IDLE, CY_STROBE, CY_RECOVER
   } fsp_cyc_t;

endpackage : fsp_pkg

// ==== logic/fsp_bus_cycle.sv ====
`timescale 1ns/1ps
module fsp_bus_cycle #(
   parameter int STROBE  = fsp_pkg::STROBE_CYC,
   parameter int RECOVER = fsp_pkg::RECOVER_CYC
) (
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   // request from the sequencer
   input  wire logic        i_req,
   input  wire logic        i_we,
   input  wire logic [18:0] i_addr,
   input  wire logic [7:0]  i_wdata,
   output logic             o_ack,
   output logic [7:0]       o_rdata,
   // flash pins
   output logic [18:0]      o_addr,
   output logic             o_ce_n,
   output logic             o_oe_n,
   output logic             o_we_n,
   input  wire logic [7:0]  i_dq,
   output logic [7:0]       o_dq,
   output logic             o_dq_oe_n
);

   if (STROBE < 1 || STROBE > 15 || RECOVER < 1 || RECOVER > 15) begin : g_chk
      $error("fsp_bus_cycle: strobe and recovery must be 1..15 cycles");
   end

   fsp_pkg::fsp_cyc_t cyc_q;
   logic [3:0]        cnt_q;
   logic              we_q;

   wire last_w = (cnt_q == 4'h1);

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         cyc_q     <= fsp_pkg::CY_IDLE;
         cnt_q     <= 4'h0;
         we_q      <= 1'b0;
         o_ack     <= 1'b0;
         o_rdata   <= 8'h00;
         o_addr    <= 19'h00000;
         o_ce_n    <= 1'b1;
         o_oe_n    <= 1'b1;
         o_we_n    <= 1'b1;
         o_dq      <= 8'h00;
         o_dq_oe_n <= 1'b1;
      end else begin
         o_ack <= 1'b0;
         case (cyc_q)
            fsp_pkg::CY_IDLE: begin
               if (i_req) begin
                  cyc_q     <= fsp_pkg::CY_STROBE;
                  cnt_q     <= 4'(STROBE);
                  we_q      <= i_we;
                  o_addr    <= i_addr;
                  o_ce_n    <= 1'b0;
                  o_oe_n    <= i_we;
                  o_we_n    <= ~i_we;
                  o_dq      <= i_wdata;
                  o_dq_oe_n <= ~i_we;
               end
            end
            fsp_pkg::CY_STROBE: begin
               cnt_q <= cnt_q - 4'h1;
               if (last_w) begin
                  // data latches on the rising strobe; keep driving through recovery for hold
                  cyc_q  <= fsp_pkg::CY_RECOVER;
                  cnt_q  <= 4'(RECOVER);
                  o_ack  <= 1'b1;
                  o_ce_n <= 1'b1;
                  o_oe_n <= 1'b1;
                  o_we_n <= 1'b1;
                  if (!we_q) o_rdata <= i_dq;
               end
            end
            default: begin
               cnt_q <= cnt_q - 4'h1;
               if (last_w) begin
                  cyc_q     <= fsp_pkg::CY_IDLE;
                  o_dq_oe_n <= 1'b1;
               end
            end
         endcase
      end
   end

   // edges seen with chip enable low; strobe may exceed what a repetition can unroll
   logic [3:0] low_cnt_q;

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         low_cnt_q <= 4'h0;
      end else if (!o_ce_n) begin
         low_cnt_q <= low_cnt_q + 4'h1;
      end else begin
         low_cnt_q <= 4'h0;
      end
   end

   a_strobe_width: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      $rose(o_ce_n) |-> (low_cnt_q == 4'(STROBE)) && o_ack)
      else $error("flash strobe width wrong");

endmodule : fsp_bus_cycle

// ==== logic/fsp_poll_ctrl.sv ====
`timescale 1ns/1ps
// Device behaviour this block relies on and host rules it follows
// RULE1 - device inverts bit 7 while programming
// RULE2 - same inversion for program during suspend
// RULE3 - host polls bit 7 at program address
// RULE4 - protected program target: status about 2 us
// RULE5 - erase reads 0, then 1 done/suspended
// RULE6 - host polls erase inside selected sector
// RULE7 - all erase sectors protected: status 100 us
// RULE8 - partly protected erase skips protected sectors
// RULE9 - take array data on the following read
// RULE10 - bit 7 status valid after last write
// RULE11 - toggle bit one flips every status read
// RULE12 - toggle bit valid including erase time-out
// RULE13 - all protected erase: toggle for 100 us
// RULE14 - protected program: toggle for 2 us
// RULE15 - toggle stops when erase suspends
// RULE16 - toggle during suspended program until done
// RULE17 - sector toggle flips inside selected sectors
// RULE18 - sector toggle valid after last write
// RULE19 - read twice; stable toggle means done
// RULE20 - toggling with limit bit: recheck, fail, reset
// RULE21 - resumed polling restarts at double read
// RULE22 - device sets limit bit on overrun
// RULE23 - reset is one write of F0
// RULE24 - host bounds polls, expiry means failure
module fsp_poll_ctrl (
   // clock and reset
   input  wire logic        I_MCLK,
   input  wire logic        I_RST_N,
   // avalon-mm slave
   input  wire logic [2:0]  I_AVS_ADDRESS,
   input  wire logic        I_AVS_READ,
   input  wire logic        I_AVS_WRITE,
   input  wire logic [31:0] I_AVS_WRITEDATA,
   output logic [31:0]      O_AVS_READDATA,
   output logic             O_AVS_WAITREQUEST,
   // flash pins
   output logic [18:0]      O_FL_ADDR,
   output logic             O_FL_CE_N,
   output logic             O_FL_OE_N,
   output logic             O_FL_WE_N,
   input  wire logic [7:0]  I_FL_DQ,
   output logic [7:0]       O_FL_DQ,
   output logic             O_FL_DQ_OE_N
);

   ////////////////////////////////////////////////////////////////////////////////
   // registers
   fsp_pkg::fsp_state_t state_q;
   logic [2:0]          cmd_q;
   logic [18:0]         addr_q;
   logic [7:0]          wdata_q;
   logic [15:0]         limit_q;
   logic [15:0]         polls_q;
   logic [7:0]          first_q;
   logic [7:0]          second_q;
   logic [7:0]          rdata_q;
   logic                recheck_q;
   logic                done_q;
   logic                ok_q;
   logic                fail_lim_q;
   logic                fail_to_q;
   logic                sect_tog_q;
   logic                rd_ack_q;

   logic                cyc_ack;
   logic [7:0]          cyc_rdata;

   ////////////////////////////////////////////////////////////////////////////////
   // decode
   wire busy_w      = (state_q != fsp_pkg::ST_IDLE);
   wire wr_ctrl_w   = I_AVS_WRITE && (I_AVS_ADDRESS == fsp_pkg::REG_CTRL) && !busy_w;
   wire toggle_md_w = (cmd_q == fsp_pkg::CMD_POLL_TOGGLE);
   wire poll_md_w   = toggle_md_w || (cmd_q == fsp_pkg::CMD_POLL_DATA);
   wire limit_w     = second_q[fsp_pkg::LIMIT_EXCEEDED_BIT];
   wire timeout_w   = (polls_q >= limit_q);
   // toggle mode: two reads agree; polarity mode: bit 7 shows the true value
   wire tog_still_w = (first_q[fsp_pkg::TOGGLE_BIT_ONE] ==
                       second_q[fsp_pkg::TOGGLE_BIT_ONE]);
   wire pol_true_w  = (second_q[fsp_pkg::COMPLETION_POLARITY_BIT] ==
                       wdata_q[fsp_pkg::COMPLETION_POLARITY_BIT]);
   wire finished_w  = toggle_md_w ? tog_still_w : pol_true_w;
   wire eval_w      = (state_q == fsp_pkg::ST_EVAL);
   wire sect_flip_w = (first_q[fsp_pkg::SECTOR_TOGGLE_BIT] !=
                       second_q[fsp_pkg::SECTOR_TOGGLE_BIT]);

   wire fsp_pkg::fsp_state_t again_w = toggle_md_w ? fsp_pkg::ST_RD_A : fsp_pkg::ST_RD_B;

   wire cyc_req_w = busy_w && !eval_w;
   wire cyc_we_w  = (state_q == fsp_pkg::ST_WR) || (state_q == fsp_pkg::ST_RESET);
   wire [7:0] cyc_wdata_w = (state_q == fsp_pkg::ST_RESET) ? fsp_pkg::RESET_BYTE : wdata_q;

   wire [31:0] status_w = {26'h0000000, sect_tog_q, fail_to_q, fail_lim_q, ok_q, done_q, busy_w};
   wire [31:0] rd_mux_w =
      (I_AVS_ADDRESS == fsp_pkg::REG_CTRL)   ? {29'h00000000, cmd_q} :
      (I_AVS_ADDRESS == fsp_pkg::REG_ADDR)   ? {13'h0000, addr_q} :
      (I_AVS_ADDRESS == fsp_pkg::REG_WDATA)  ? {24'h000000, wdata_q} :
      (I_AVS_ADDRESS == fsp_pkg::REG_LIMIT)  ? {16'h0000, limit_q} :
      (I_AVS_ADDRESS == fsp_pkg::REG_STATUS) ? status_w :
      (I_AVS_ADDRESS == fsp_pkg::REG_RDATA)  ? {24'h000000, rdata_q} : 32'h00000000;

   // reads take one wait state so read data comes from a flop
   assign O_AVS_WAITREQUEST = I_AVS_READ && !rd_ack_q;

   ////////////////////////////////////////////////////////////////////////////////
   // bus slave
   always_ff @(posedge I_MCLK) begin
      if (!I_RST_N) begin
         rd_ack_q       <= 1'b0;
         O_AVS_READDATA <= 32'h00000000;
         addr_q         <= 19'h00000;
         wdata_q        <= 8'h00;
         limit_q        <= fsp_pkg::LIMIT_RST;
      end else begin
         rd_ack_q <= I_AVS_READ && !rd_ack_q;
         if (I_AVS_READ && !rd_ack_q) O_AVS_READDATA <= rd_mux_w;
         // operands are frozen while an operation runs
         if (I_AVS_WRITE && !busy_w) begin
            if (I_AVS_ADDRESS == fsp_pkg::REG_ADDR)  addr_q  <= I_AVS_WRITEDATA[18:0];
            if (I_AVS_ADDRESS == fsp_pkg::REG_WDATA) wdata_q <= I_AVS_WRITEDATA[7:0];
            if (I_AVS_ADDRESS == fsp_pkg::REG_LIMIT) limit_q <= I_AVS_WRITEDATA[15:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // sequencer
   always_ff @(posedge I_MCLK) begin
      if (!I_RST_N) begin
         state_q    <= fsp_pkg::ST_IDLE;
         cmd_q      <= 3'h0;
         polls_q    <= 16'h0000;
         first_q    <= 8'h00;
         second_q   <= 8'h00;
         rdata_q    <= 8'h00;
         recheck_q  <= 1'b0;
         done_q     <= 1'b0;
         ok_q       <= 1'b0;
         fail_lim_q <= 1'b0;
         fail_to_q  <= 1'b0;
         sect_tog_q <= 1'b0;
      end else begin
         case (state_q)
            fsp_pkg::ST_IDLE: begin
               if (wr_ctrl_w) begin
                  cmd_q      <= I_AVS_WRITEDATA[2:0];
                  polls_q    <= 16'h0000;
                  recheck_q  <= 1'b0;
                  done_q     <= 1'b0;
                  ok_q       <= 1'b0;
                  fail_lim_q <= 1'b0;
                  fail_to_q  <= 1'b0;
                  sect_tog_q <= 1'b0;
                  case (I_AVS_WRITEDATA[2:0])
                     fsp_pkg::CMD_WRITE:       state_q <= fsp_pkg::ST_WR;
                     fsp_pkg::CMD_READ:        state_q <= fsp_pkg::ST_RD;
                     fsp_pkg::CMD_POLL_TOGGLE: state_q <= fsp_pkg::ST_RD_A; // RULE19
                     fsp_pkg::CMD_POLL_DATA:   state_q <= fsp_pkg::ST_RD_B;
                     fsp_pkg::CMD_RESET:       state_q <= fsp_pkg::ST_RESET; // RULE23
                     default:                  state_q <= fsp_pkg::ST_IDLE;
                  endcase
               end
            end
            fsp_pkg::ST_RD_A: begin
               if (cyc_ack) begin
                  first_q <= cyc_rdata;
                  state_q <= fsp_pkg::ST_RD_B;
               end
            end
            fsp_pkg::ST_RD_B: begin
               if (cyc_ack) begin
                  second_q <= cyc_rdata;
                  state_q  <= fsp_pkg::ST_EVAL;
               end
            end
            fsp_pkg::ST_EVAL: begin
               if (toggle_md_w && sect_flip_w) sect_tog_q <= 1'b1;
               if (finished_w) begin
                  state_q <= fsp_pkg::ST_FINAL; // RULE9 RULE19
               end else if (limit_w) begin
                  if (recheck_q) begin
                     fail_lim_q <= 1'b1; // RULE20
                     state_q    <= fsp_pkg::ST_RESET;
                  end else begin
                     // toggling may have stopped just as the limit bit rose
                     recheck_q <= 1'b1; // RULE20
                     state_q   <= again_w;
                  end
               end else if (timeout_w) begin
                  fail_to_q <= 1'b1; // RULE24
                  state_q   <= fsp_pkg::ST_RESET;
               end else begin
                  polls_q <= polls_q + 16'h0001;
                  state_q <= again_w; // RULE21
               end
            end
            fsp_pkg::ST_WR: begin
               if (cyc_ack) begin
                  done_q  <= 1'b1;
                  ok_q    <= 1'b1;
                  state_q <= fsp_pkg::ST_IDLE;
               end
            end
            fsp_pkg::ST_RESET: begin
               if (cyc_ack) begin
                  done_q  <= 1'b1;
                  ok_q    <= !(fail_lim_q || fail_to_q);
                  state_q <= fsp_pkg::ST_IDLE;
               end
            end
            default: begin
               // plain read and the array read after a finished poll
               if (cyc_ack) begin
                  rdata_q <= cyc_rdata; // RULE9
                  done_q  <= 1'b1;
                  ok_q    <= 1'b1;
                  state_q <= fsp_pkg::ST_IDLE;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // flash bus cycles; every poll read uses the programmed or erasing address
   fsp_bus_cycle #(
      .STROBE  (fsp_pkg::STROBE_CYC),
      .RECOVER (fsp_pkg::RECOVER_CYC)
   ) u_cycle (
      .i_clk     (I_MCLK),
      .i_rst_n   (I_RST_N),
      .i_req     (cyc_req_w),
      .i_we      (cyc_we_w),
      .i_addr    (addr_q), // RULE3 RULE6
      .i_wdata   (cyc_wdata_w),
      .o_ack     (cyc_ack),
      .o_rdata   (cyc_rdata),
      .o_addr    (O_FL_ADDR),
      .o_ce_n    (O_FL_CE_N),
      .o_oe_n    (O_FL_OE_N),
      .o_we_n    (O_FL_WE_N),
      .i_dq      (I_FL_DQ),
      .o_dq      (O_FL_DQ),
      .o_dq_oe_n (O_FL_DQ_OE_N)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge I_MCLK); endclocking
   default disable iff (!I_RST_N);

   sequence s_reset_write;
      (state_q == fsp_pkg::ST_RESET) ##[1:30] (state_q == fsp_pkg::ST_IDLE && done_q);
   endsequence

   a_poll_address: assert property ( // RULE3 RULE6
      (poll_md_w && busy_w && !O_FL_OE_N) |-> (O_FL_ADDR == addr_q))
      else $error("status read not at the polled address");

   a_final_read: assert property ( // RULE9
      (eval_w && finished_w) |=> (state_q == fsp_pkg::ST_FINAL) ##[1:30] (done_q && ok_q))
      else $error("no array read after completion");

   a_double_read: assert property ( // RULE19
      (state_q == fsp_pkg::ST_RD_A && cyc_ack) |=> (state_q == fsp_pkg::ST_RD_B))
      else $error("toggle poll did not read twice");

   a_limit_recheck: assert property ( // RULE20
      (eval_w && !finished_w && limit_w && !recheck_q)
      |=> recheck_q && (state_q == fsp_pkg::ST_RD_A || state_q == fsp_pkg::ST_RD_B))
      else $error("limit bit seen without recheck");

   a_fail_reset: assert property ( // RULE20
      (eval_w && !finished_w && limit_w && recheck_q) |=> fail_lim_q ##0 s_reset_write)
      else $error("failed operation not followed by reset");

   a_reset_byte: assert property ( // RULE23
      (state_q == fsp_pkg::ST_RESET && !O_FL_WE_N)
      |-> (O_FL_DQ == fsp_pkg::RESET_BYTE) && !O_FL_DQ_OE_N && !O_FL_CE_N)
      else $error("reset write not F0");

   a_poll_timeout: assert property ( // RULE24
      (eval_w && !finished_w && !limit_w && timeout_w)
      |=> fail_to_q && (state_q == fsp_pkg::ST_RESET))
      else $error("poll limit not enforced");

   a_restart_pair: assert property ( // RULE21
      (eval_w && toggle_md_w && !finished_w && !limit_w && !timeout_w)
      |=> (state_q == fsp_pkg::ST_RD_A) && (polls_q == $past(polls_q) + 16'h0001))
      else $error("resumed polling skipped first read");

endmodule : fsp_poll_ctrl

// ==== verif/fsp_flash_model.sv ====
`timescale 1ns/1ps
module fsp_flash_model (
   // flash pins from the controller
   input  wire logic [18:0] i_addr,
   input  wire logic        i_ce_n,
   input  wire logic        i_oe_n,
   input  wire logic        i_we_n,
   input  wire logic [7:0]  i_dq,
   input  wire logic        i_dq_oe_n,
   // data driven back by the device
   output logic [7:0]       o_dq
);
   logic [7:0] mem [0:127];
   logic [7:0] prot;
   logic [7:0] esec;
   logic [7:0] pd;
   logic [7:0] q;
   logic       ers;
   logic       susp;
   logic       fail;
   logic       fail_next;
   logic       tog6;
   logic       tog2;
   logic       busy;
   logic       in_sec;
   realtime    t_end;
   realtime    prog_ns;
   int         f0_cnt;
   wire        rd_n = i_oe_n | i_ce_n;
   wire        wr_n = i_we_n | i_ce_n;
   wire [6:0]  idx  = {i_addr[18:16], i_addr[3:0]};

   initial begin
      {prot, esec, pd, q} = 32'h00000000;
      {ers, susp, fail, fail_next, tog6, tog2} = 6'h00;
      t_end = 0.0;
      prog_ns = 1500.0;
      f0_cnt = 0;
   end

   // a deselected bus shows the inverse of the last byte, so a late sample is caught
   assign o_dq = rd_n ? ~q : q;

   ////////////////////////////////////////////////////////////////////////////////
   always @(negedge rd_n) begin
      busy   = fail || ($realtime < t_end);
      in_sec = esec[i_addr[18:16]];
      if (busy && !ers) begin
         tog6 = ~tog6;
         q    = {~pd[7], tog6, fail, 5'h00};
      end else if (busy) begin
         tog6 = ~tog6;
         tog2 = tog2 ^ in_sec;
         q    = {1'b0, tog6, 3'h0, tog2, 2'h0};
      end else if (susp && in_sec) begin
         tog2 = ~tog2;
         q    = {1'b1, tog6, 3'h0, tog2, 2'h0};
      end else begin
         ers = 1'b0;
         q   = mem[idx];
      end
   end

   // data latches on whichever of write strobe or chip select rises first
   always @(posedge wr_n) begin
      busy = fail || ($realtime < t_end);
      if (i_dq_oe_n !== 1'b0) begin
         // strobes leaving unknown at power-up, no data driven: not a write
      end else if (i_dq == 8'hF0) begin
         fail  = 1'b0;
         t_end = 0.0;
         f0_cnt++;
      end else if (!busy) begin
         pd        = i_dq;
         fail      = fail_next;
         fail_next = 1'b0;
         if (!prot[i_addr[18:16]]) mem[idx] = i_dq;
         t_end = $realtime + (prot[i_addr[18:16]] ? 2000.0 : prog_ns);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic start_erase(input logic [7:0] sel, input realtime dur);
      esec  = sel & ~prot;
      ers   = 1'b1;
      susp  = 1'b0;
      t_end = $realtime + ((esec == 8'h00) ? 100000.0 : dur);
      for (int k = 0; k < 128; k++) begin
         if (esec[k[6:4]]) mem[k] = 8'hFF;
      end
   endtask : start_erase

   task automatic suspend();
      ers   = 1'b0;
      susp  = 1'b1;
      t_end = 0.0;
   endtask : suspend
endmodule : fsp_flash_model

// ==== verif/tb_flash_write_status_reporting.sv ====
`timescale 1ns/1ps
module tb_flash_write_status_reporting;
   typedef struct {logic [2:0] adr; logic [31:0] exp; logic [31:0] mask;} fsp_note_t;
   logic        clk;
   logic        rst_n;
   logic [2:0]  avs_addr;
   logic        avs_rd;
   logic        avs_wr;
   logic [31:0] avs_wdata;
   logic [31:0] avs_rdata;
   logic        avs_wait;
   logic [18:0] fl_addr;
   logic        fl_ce_n;
   logic        fl_oe_n;
   logic        fl_we_n;
   logic [7:0]  fl_din;
   logic [7:0]  fl_dout;
   logic        fl_dq_oe_n;
   fsp_note_t   notes[$];
   fsp_note_t   nt;
   logic [31:0] dummy;
   int          mismatches = 0;
   int          n_checks = 0;
   int          cyc = 0;

   fsp_poll_ctrl DUT (.I_MCLK(clk), .I_RST_N(rst_n), .I_AVS_ADDRESS(avs_addr),
      .I_AVS_READ(avs_rd), .I_AVS_WRITE(avs_wr), .I_AVS_WRITEDATA(avs_wdata),
      .O_AVS_READDATA(avs_rdata), .O_AVS_WAITREQUEST(avs_wait), .O_FL_ADDR(fl_addr),
      .O_FL_CE_N(fl_ce_n), .O_FL_OE_N(fl_oe_n), .O_FL_WE_N(fl_we_n), .I_FL_DQ(fl_din),
      .O_FL_DQ(fl_dout), .O_FL_DQ_OE_N(fl_dq_oe_n));
   fsp_flash_model dev (.i_addr(fl_addr), .i_ce_n(fl_ce_n), .i_oe_n(fl_oe_n),
      .i_we_n(fl_we_n), .i_dq(fl_dout), .i_dq_oe_n(fl_dq_oe_n), .o_dq(fl_din));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr

   function automatic logic [18:0] fa(input logic [2:0] s, input logic [3:0] w);
      return {s, 12'h000, w};
   endfunction : fa

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : final_report

   task automatic avs_read(input logic [2:0] a, input logic [31:0] e, input logic [31:0] m,
                           output logic [31:0] d);
      notes.push_back('{a, e, m});
      @(posedge clk);
      avs_addr <= a;
      avs_rd   <= 1'b1;
      do @(posedge clk); while (avs_wait !== 1'b0);
      d = avs_rdata;
      avs_rd <= 1'b0;
   endtask : avs_read

   task automatic avs_write(input logic [2:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_addr  <= a;
      avs_wdata <= d;
      avs_wr    <= 1'b1;
      do @(posedge clk); while (avs_wait !== 1'b0);
      avs_wr <= 1'b0;
   endtask : avs_write

   task automatic expect_reg(input logic [2:0] a, input logic [31:0] e, input logic [31:0] m);
      avs_read(a, e, m, dummy);
   endtask : expect_reg

   task automatic start_cmd(input logic [2:0] c, input logic [18:0] a, input logic [7:0] d);
      avs_write(fsp_pkg::REG_ADDR, {13'h0000, a});
      avs_write(fsp_pkg::REG_WDATA, {24'h000000, d});
      avs_write(fsp_pkg::REG_CTRL, {29'h00000000, c});
   endtask : start_cmd

   // bounded by the global cycle limit as well
   task automatic wait_idle();
      logic [31:0] st;
      st = 32'h00000001;
      for (int i = 0; i < 5000 && st[fsp_pkg::ST_BUSY] !== 1'b0; i++) begin
         avs_read(fsp_pkg::REG_STATUS, 32'h00000000, 32'h00000000, st);
      end
   endtask : wait_idle

   task automatic run_cmd(input logic [2:0] c, input logic [18:0] a, input logic [7:0] d);
      start_cmd(c, a, d);
      wait_idle();
   endtask : run_cmd

   task automatic expect_end(input logic [5:0] st, input logic [7:0] rd, input logic [7:0] m);
      expect_reg(fsp_pkg::REG_STATUS, {26'h0000000, st}, 32'h0000003F);
      if (m != 8'h00) expect_reg(fsp_pkg::REG_RDATA, {24'h000000, rd}, {24'h000000, m});
   endtask : expect_end

   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (avs_rd === 1'b1 && avs_wait === 1'b0 && notes.size() > 0) begin
         nt = notes.pop_front();
         if (nt.mask !== 32'h00000000) check($sformatf("reg%0d", nt.adr), avs_rdata & nt.mask, nt.exp);
      end
      if (cyc == 30000) begin
         mismatches++;
         final_report();
      end
   end

   initial begin
      logic [31:0] r;
      logic [7:0]  d;
      logic [7:0]  old;
      r = 32'hA2115C46;
      {rst_n, avs_rd, avs_wr, avs_addr, avs_wdata} = 38'h0000000000;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      for (int k = 0; k < 128; k++) begin
         r = lfsr(r);
         dev.mem[k] = r[7:0];
      end
      for (int k = 0; k < 8; k++) begin
         expect_reg(k[2:0], (k == 3) ? {16'h0000, fsp_pkg::LIMIT_RST} : 32'h0, 32'hFFFFFFFF);
      end
      run_cmd(fsp_pkg::CMD_READ, fa(3'h1, 4'h5), 8'h00);
      expect_end(6'h06, dev.mem[7'h15], 8'hFF);
      r = lfsr(r);
      d = r[7:0] & 8'hEF;
      run_cmd(fsp_pkg::CMD_WRITE, fa(3'h0, 4'h2), d);
      run_cmd(fsp_pkg::CMD_POLL_DATA, fa(3'h0, 4'h2), d);
      expect_end(6'h06, d, 8'hFF);
      check("written byte", {24'h000000, dev.pd}, {24'h000000, d});
      r = lfsr(r);
      // bit 2 kept low so the status-to-array pair shows no sector toggle
      d = r[7:0] & 8'hEB;
      run_cmd(fsp_pkg::CMD_WRITE, fa(3'h1, 4'h3), d);
      run_cmd(fsp_pkg::CMD_POLL_TOGGLE, fa(3'h1, 4'h3), 8'h00);
      expect_end(6'h06, d, 8'hFF);
      // a write into a locked sector keeps the old byte
      dev.prot = 8'h04;
      old = dev.mem[7'h24] & 8'hFB;
      dev.mem[7'h24] = old;
      run_cmd(fsp_pkg::CMD_WRITE, fa(3'h2, 4'h4), ~old & 8'hEF);
      run_cmd(fsp_pkg::CMD_POLL_TOGGLE, fa(3'h2, 4'h4), 8'h00);
      expect_end(6'h06, old, 8'hFF);
      dev.prot = 8'h00;
      dev.start_erase(8'h08, 3000.0);
      run_cmd(fsp_pkg::CMD_POLL_TOGGLE, fa(3'h3, 4'h1), 8'h00);
      expect_end(6'h26, 8'hFF, 8'hFF);
      dev.prot = 8'h20;
      old = dev.mem[7'h52];
      dev.start_erase(8'h30, 3000.0);
      run_cmd(fsp_pkg::CMD_POLL_DATA, fa(3'h4, 4'h0), 8'hFF);
      expect_end(6'h06, 8'hFF, 8'hFF);
      run_cmd(fsp_pkg::CMD_READ, fa(3'h5, 4'h2), 8'h00);
      expect_end(6'h06, old, 8'hFF);
      // every selected sector locked: erase status for the long window, data untouched
      dev.prot = 8'h80;
      dev.mem[7'h70] = 8'hA5;
      dev.start_erase(8'h80, 3000.0);
      run_cmd(fsp_pkg::CMD_POLL_DATA, fa(3'h7, 4'h0), 8'hFF);
      expect_end(6'h06, 8'hA5, 8'hFF);
      dev.prot = 8'h00;
      dev.start_erase(8'h40, 100000.0);
      dev.suspend();
      r = lfsr(r);
      d = r[7:0] & 8'hEF;
      run_cmd(fsp_pkg::CMD_WRITE, fa(3'h0, 4'h7), d);
      run_cmd(fsp_pkg::CMD_POLL_DATA, fa(3'h0, 4'h7), d);
      expect_end(6'h06, d, 8'hFF);
      run_cmd(fsp_pkg::CMD_POLL_TOGGLE, fa(3'h6, 4'h0), 8'h00);
      expect_end(6'h26, 8'h80, 8'h80);
      dev.susp = 1'b0;
      dev.fail_next = 1'b1;
      run_cmd(fsp_pkg::CMD_WRITE, fa(3'h1, 4'h9), d);
      run_cmd(fsp_pkg::CMD_POLL_TOGGLE, fa(3'h1, 4'h9), 8'h00);
      expect_end(6'h0A, 8'h00, 8'h00);
      check("reset writes", 32'(dev.f0_cnt), 32'h00000001);
      // a never-ending write must be cut short by the poll limit
      avs_write(fsp_pkg::REG_LIMIT, 32'h00000002);
      dev.prog_ns = 1000000.0;
      run_cmd(fsp_pkg::CMD_WRITE, fa(3'h2, 4'h1), d);
      start_cmd(fsp_pkg::CMD_POLL_TOGGLE, fa(3'h2, 4'h1), 8'h00);
      avs_write(fsp_pkg::REG_LIMIT, 32'h00000007);
      wait_idle();
      expect_end(6'h12, 8'h00, 8'h00);
      expect_reg(fsp_pkg::REG_LIMIT, 32'h00000002, 32'hFFFFFFFF);
      check("reset writes", 32'(dev.f0_cnt), 32'h00000002);
      run_cmd(fsp_pkg::CMD_RESET, fa(3'h7, 4'h0), 8'h00);
      check("reset writes", 32'(dev.f0_cnt), 32'h00000003);
      // an unknown code starts nothing but still clears the finished flags
      avs_write(fsp_pkg::REG_CTRL, 32'h00000006);
      expect_end(6'h00, 8'h00, 8'h00);
      final_report();
   end
endmodule : tb_flash_write_status_reporting
